// ==== design/pfcbl_defs.svh ====
`ifndef PFCBL_DEFS_SVH
`define PFCBL_DEFS_SVH

// Register indices; the byte address is four times the index
`define PFCBL_IDX_RELOAD 16'h40e4
`define PFCBL_IDX_DUTY 16'h40e6
`define PFCBL_IDX_SETPOINT 16'h40e8
`define PFCBL_IDX_OUTPUT 16'h40ea
`define PFCBL_IDX_KP 16'h40ec
`define PFCBL_IDX_KI 16'h40ee
`define PFCBL_IDX_CEILING 16'h40f0
`define PFCBL_IDX_FLOOR 16'h40f2
`define PFCBL_IDX_CONTROL 16'h4100
`define PFCBL_IDX_STATUS 16'h4101
`define PFCBL_IDX_MASK 16'h4102

// Field widths and positions
`define PFCBL_CW 12
`define PFCBL_GW 15
`define PFCBL_ACCW 24
`define PFCBL_AVG_SHIFT 8
`define PFCBL_KP_Q 10
`define PFCBL_KI_Q 15
`define PFCBL_DUTY_HI 14
`define PFCBL_DUTY_LO 3
`define PFCBL_EVW 3
`define PFCBL_EV_OVF 0
`define PFCBL_EV_SAT 1
`define PFCBL_EV_AVG 2
`define PFCBL_CTRL_EN 0

// Constants
`define PFCBL_ZERO16 16'h0000
`define PFCBL_CNT_ONE 12'h001
`define PFCBL_CNT_ZERO 12'h000
`define PFCBL_SAMP_LAST 8'hff

`endif

// ==== design/pfcbl_pkg.sv ====
`include "pfcbl_defs.svh"

package pfcbl_pkg;

  typedef enum logic {PFCBL_UP, PFCBL_DOWN} pfcbl_dir_t;

  typedef struct packed {
    logic [`PFCBL_CW-1:0] cnt;
    pfcbl_dir_t dir;
    logic [`PFCBL_CW-1:0] reload;
    logic [`PFCBL_CW-1:0] duty;
    logic pwm;
    logic [15:0] setp;
    logic [15:0] uk;
    logic [`PFCBL_GW-1:0] kp;
    logic [`PFCBL_GW-1:0] ki;
    logic [15:0] ceil;
    logic [15:0] floor;
    logic en;
    logic [16:0] eprev;
    logic [15:0] avg;
    logic [`PFCBL_ACCW-1:0] acc;
    logic [7:0] nsamp;
    logic [`PFCBL_EVW-1:0] status;
    logic [`PFCBL_EVW-1:0] mask;
    logic irq;
    logic ack;
    logic [15:0] dat;
  } pfcbl_state_t;

endpackage : pfcbl_pkg

// ==== design/pfcbl_top.sv ====
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ns
`include "pfcbl_defs.svh"
module pfcbl_top
  import pfcbl_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] line_voltage_sample_i,
  input wire logic line_sample_valid_i,
  input wire logic [15:0] dc_bus_voltage_i,
  input wire logic dc_bus_valid_i,
  output logic pwm_o,
  output logic irq_o
);

  pfcbl_state_t r;
  pfcbl_state_t n;
  logic [15:0] idx;
  logic wr;
  logic wr_uk;
  logic wr_duty;
  logic signed [16:0] e;
  logic signed [17:0] de;
  logic signed [33:0] pterm;
  logic signed [32:0] iterm;
  logic signed [35:0] sum;
  logic signed [15:0] lo;
  logic [15:0] uk_new;
  logic sat;
  logic [`PFCBL_EVW-1:0] ev;
  logic [`PFCBL_ACCW-1:0] acc_sum;

  // Register index hit for a given address
  function automatic logic hit(input logic [15:0] a, input logic [15:0] k);
    hit = (a == k);
  endfunction : hit

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] sel);
    merge16 = old;
    if (sel[0]) begin
      merge16[7:0] = d[7:0];
    end
    if (sel[1]) begin
      merge16[15:8] = d[15:8];
    end
  endfunction : merge16

  assign idx = wb_adr_i[17:2];
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & r.ack;
  assign wr_uk = wr & hit(idx, `PFCBL_IDX_OUTPUT);
  assign wr_duty = wr & hit(idx, `PFCBL_IDX_DUTY) & ~r.en;

  // Loop error, increments and the two gain terms
  always_comb begin
    if (r.en) begin
      e = $signed({r.setp[15], r.setp})
        - $signed({dc_bus_voltage_i[15], dc_bus_voltage_i});
    end else begin
      e = $signed({r.setp[15], r.setp});
    end
    de = $signed({e[16], e}) - $signed({r.eprev[16], r.eprev});
    pterm = $signed({1'b0, r.kp}) * de;
    iterm = $signed({1'b0, r.ki}) * e;
    sum = 36'(signed'(r.uk)) + 36'(pterm >>> `PFCBL_KP_Q)
        + 36'(iterm >>> `PFCBL_KI_Q);
    lo = r.en ? $signed(`PFCBL_ZERO16) : $signed(r.floor);
    sat = 1'b0;
    uk_new = sum[15:0];
    if (sum < 36'(lo)) begin
      uk_new = lo;
      sat = 1'b1;
    end
    if (sum > 36'($signed(r.ceil))) begin
      uk_new = r.ceil;
      sat = 1'b1;
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    n = r;
    ev = '0;
    acc_sum = r.acc + {{(`PFCBL_ACCW-16){line_voltage_sample_i[15]}}, line_voltage_sample_i};

    // Center-aligned carrier counter
    if (r.dir == PFCBL_UP) begin
      if (r.cnt >= r.reload) begin
        n.dir = PFCBL_DOWN;
        n.cnt = (r.cnt == `PFCBL_CNT_ZERO) ? `PFCBL_CNT_ZERO : r.cnt - `PFCBL_CNT_ONE;
        ev[`PFCBL_EV_OVF] = (r.cnt == r.reload);
      end else begin
        n.cnt = r.cnt + `PFCBL_CNT_ONE;
      end
    end else begin
      if (r.cnt == `PFCBL_CNT_ZERO) begin
        n.dir = PFCBL_UP;
        n.cnt = (r.reload == `PFCBL_CNT_ZERO) ? `PFCBL_CNT_ZERO : `PFCBL_CNT_ONE;
      end else begin
        n.cnt = r.cnt - `PFCBL_CNT_ONE;
      end
    end

    // PWM compare; equal keeps the previous level
    if (r.duty > r.cnt) begin
      n.pwm = 1'b1;
    end else if (r.duty < r.cnt) begin
      n.pwm = 1'b0;
    end else begin
      n.pwm = r.pwm;
    end

    // Line-voltage average over a fixed window of samples per mains period
    if (line_sample_valid_i) begin
      n.nsamp = r.nsamp + 8'h01;
      if (r.nsamp == `PFCBL_SAMP_LAST) begin
        n.avg = 16'(signed'(acc_sum) >>> `PFCBL_AVG_SHIFT);
        n.acc = '0;
        ev[`PFCBL_EV_AVG] = 1'b1;
      end else begin
        n.acc = acc_sum;
      end
    end

    // Bus-voltage loop evaluation on each bus sample
    if (dc_bus_valid_i) begin
      n.uk = uk_new;
      n.eprev = e;
      ev[`PFCBL_EV_SAT] = sat;
      if (r.en) begin
        n.duty = uk_new[`PFCBL_DUTY_HI:`PFCBL_DUTY_LO];
      end
    end

    // Wishbone answer one cycle after the strobe, dropped the cycle after
    n.ack = wb_cyc_i & wb_stb_i & ~r.ack;
    if (n.ack) begin
      n.dat = `PFCBL_ZERO16;
      case (idx)
        `PFCBL_IDX_RELOAD: n.dat = r.avg;
        `PFCBL_IDX_DUTY: n.dat = {4'h0, r.duty};
        `PFCBL_IDX_SETPOINT: n.dat = r.setp;
        `PFCBL_IDX_OUTPUT: n.dat = r.uk;
        `PFCBL_IDX_KP: n.dat = {1'b0, r.kp};
        `PFCBL_IDX_KI: n.dat = {1'b0, r.ki};
        `PFCBL_IDX_CEILING: n.dat = r.ceil;
        `PFCBL_IDX_FLOOR: n.dat = r.floor;
        `PFCBL_IDX_CONTROL: n.dat = {15'h0000, r.en};
        `PFCBL_IDX_STATUS: n.dat = {13'h0000, r.status};
        `PFCBL_IDX_MASK: n.dat = {13'h0000, r.mask};
        default: n.dat = `PFCBL_ZERO16;
      endcase
    end

    // Software writes land at the edge where ack is sampled
    if (wr) begin
      case (idx)
        `PFCBL_IDX_RELOAD: n.reload = 12'(merge16({4'h0, r.reload}, wb_dat_i, wb_sel_i));
        `PFCBL_IDX_DUTY: begin
          if (!r.en) begin
            n.duty = 12'(merge16({4'h0, r.duty}, wb_dat_i, wb_sel_i));
          end
        end
        `PFCBL_IDX_SETPOINT: n.setp = merge16(r.setp, wb_dat_i, wb_sel_i);
        `PFCBL_IDX_OUTPUT: n.uk = merge16(r.uk, wb_dat_i, wb_sel_i);
        `PFCBL_IDX_KP: n.kp = 15'(merge16({1'b0, r.kp}, wb_dat_i, wb_sel_i));
        `PFCBL_IDX_KI: n.ki = 15'(merge16({1'b0, r.ki}, wb_dat_i, wb_sel_i));
        `PFCBL_IDX_CEILING: n.ceil = merge16(r.ceil, wb_dat_i, wb_sel_i);
        `PFCBL_IDX_FLOOR: n.floor = merge16(r.floor, wb_dat_i, wb_sel_i);
        `PFCBL_IDX_CONTROL: begin
          if (wb_sel_i[0]) begin
            n.en = wb_dat_i[`PFCBL_CTRL_EN];
          end
        end
        `PFCBL_IDX_MASK: begin
          if (wb_sel_i[0]) begin
            n.mask = wb_dat_i[`PFCBL_EVW-1:0];
          end
        end
        default: n.en = r.en;
      endcase
    end

    // Sticky status, write one to clear, a new event wins over the clear
    n.status = r.status | ev;
    if (wr && hit(idx, `PFCBL_IDX_STATUS) && wb_sel_i[0]) begin
      n.status = (r.status & ~wb_dat_i[`PFCBL_EVW-1:0]) | ev;
    end
    n.irq = |(n.status & n.mask);
  end

  // State register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign wb_ack_o = r.ack;
  assign wb_dat_o = {16'h0000, r.dat};
  assign pwm_o = r.pwm;
  assign irq_o = r.irq;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_peak_overflow_set: assert property (
    (r.dir == PFCBL_UP && r.cnt == r.reload) |=> r.status[`PFCBL_EV_OVF])
    else $error("Overflow flag not set at the carrier peak");

  a_carrier_turn_down: assert property (
    (r.dir == PFCBL_UP && r.cnt == r.reload && r.reload != `PFCBL_CNT_ZERO)
    |=> (r.dir == PFCBL_DOWN && r.cnt == $past(r.cnt) - `PFCBL_CNT_ONE))
    else $error("Carrier did not turn down at the reload value");

  a_carrier_turn_up: assert property (
    (r.dir == PFCBL_DOWN && r.cnt == `PFCBL_CNT_ZERO && r.reload != `PFCBL_CNT_ZERO)
    |=> (r.dir == PFCBL_UP && r.cnt == `PFCBL_CNT_ONE))
    else $error("Carrier did not turn up at zero");

  a_pwm_goes_high: assert property (
    (r.duty > r.cnt) |=> pwm_o)
    else $error("PWM not high with duty above count");

  a_pwm_goes_low: assert property (
    (r.duty < r.cnt) |=> !pwm_o)
    else $error("PWM not low with duty below count");

  a_pwm_equal_hold: assert property (
    (r.duty == r.cnt) |=> $stable(pwm_o))
    else $error("PWM changed at the crossing point");

  a_loop_ceiling_held: assert property (
    (dc_bus_valid_i && !wr_uk) |=> ($signed(r.uk) <= $signed(r.ceil) || $changed(r.ceil)))
    else $error("Loop output above the ceiling");

  a_loop_floor_held: assert property (
    (dc_bus_valid_i && !wr_uk && !r.en && $signed(r.floor) <= $signed(r.ceil))
    |=> ($signed(r.uk) >= $signed($past(r.floor))))
    else $error("Loop output below the floor");

  a_gain_msb_zero: assert property (
    (wb_ack_o && $past(idx) == `PFCBL_IDX_KP) |-> !wb_dat_o[15])
    else $error("Proportional gain bit 15 read as one");

  a_igain_msb_zero: assert property (
    (wb_ack_o && $past(idx) == `PFCBL_IDX_KI) |-> !wb_dat_o[15])
    else $error("Integral gain bit 15 read as one");

  a_reload_reads_avg: assert property (
    (wb_ack_o && $past(idx) == `PFCBL_IDX_RELOAD) |-> wb_dat_o[15:0] == $past(r.avg))
    else $error("Reload address did not read the average");

  a_duty_auto_update: assert property (
    (dc_bus_valid_i && r.en && !wr_uk)
    |=> r.duty == r.uk[`PFCBL_DUTY_HI:`PFCBL_DUTY_LO])
    else $error("Duty not updated from the loop output");

  a_duty_held_off: assert property (
    (!r.en && !wr_duty && !wr) |=> $stable(r.duty))
    else $error("Duty changed without a write while disabled");

  a_duty_locked_on: assert property (
    (r.en && !dc_bus_valid_i) |=> $stable(r.duty))
    else $error("Duty changed while correction owns it");

  // Carrier stepping between the turning points
  a_count_steps_up: assert property (
    (r.dir == PFCBL_UP && r.cnt < r.reload)
    |=> (r.dir == PFCBL_UP && r.cnt == $past(r.cnt) + `PFCBL_CNT_ONE))
    else $error("Carrier did not step up by one");

  a_count_steps_down: assert property (
    (r.dir == PFCBL_DOWN && r.cnt != `PFCBL_CNT_ZERO)
    |=> (r.dir == PFCBL_DOWN && r.cnt == $past(r.cnt) - `PFCBL_CNT_ONE))
    else $error("Carrier did not step down by one");

  a_overflow_only_peak: assert property (
    $rose(r.status[`PFCBL_EV_OVF])
    |-> ($past(r.dir) == PFCBL_UP && $past(r.cnt) == $past(r.reload)))
    else $error("Overflow flag rose away from the carrier peak");

  // Sticky flags and the interrupt level
  a_status_sticky: assert property (
    !(wr && idx == `PFCBL_IDX_STATUS)
    |=> ((r.status & $past(r.status)) == $past(r.status)))
    else $error("Status bit cleared without a write");

  a_irq_level: assert property (
    irq_o == |(r.status & r.mask))
    else $error("Interrupt level disagrees with status and mask");

  // Line-voltage average window
  a_avg_event_set: assert property (
    (line_sample_valid_i && r.nsamp == `PFCBL_SAMP_LAST) |=> r.status[`PFCBL_EV_AVG])
    else $error("Average event not flagged at the window end");

  a_avg_held: assert property (
    !line_sample_valid_i |=> $stable(r.avg))
    else $error("Average changed without a sample");

  // Loop output only moves on a bus sample or a software write
  a_loop_idle_hold: assert property (
    (!dc_bus_valid_i && !wr_uk) |=> $stable(r.uk))
    else $error("Loop output moved without a bus sample");

  a_out_write_wins: assert property (
    (wr_uk && wb_sel_i[1:0] == 2'b11) |=> (r.uk == 16'($past(wb_dat_i))))
    else $error("Loop output write did not land");

  a_sat_flag_set: assert property (
    (dc_bus_valid_i && sat) |=> r.status[`PFCBL_EV_SAT])
    else $error("Clamped loop output not flagged");

  a_floor_zero_enabled: assert property (
    (dc_bus_valid_i && !wr_uk && r.en && !r.ceil[15]) |=> !r.uk[15])
    else $error("Loop output negative with correction enabled");

  // Software writes land at the acknowledge edge
  a_setpoint_write: assert property (
    (wr && idx == `PFCBL_IDX_SETPOINT && wb_sel_i[1:0] == 2'b11)
    |=> (r.setp == 16'($past(wb_dat_i))))
    else $error("Setpoint write did not land");

  a_kp_write: assert property (
    (wr && idx == `PFCBL_IDX_KP && wb_sel_i[1:0] == 2'b11)
    |=> (r.kp == 15'($past(wb_dat_i))))
    else $error("Proportional gain write did not land");

  a_ki_write: assert property (
    (wr && idx == `PFCBL_IDX_KI && wb_sel_i[1:0] == 2'b11)
    |=> (r.ki == 15'($past(wb_dat_i))))
    else $error("Integral gain write did not land");

  // Register bus handshake
  a_ack_after_strobe: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("No acknowledge one cycle after the strobe");

  a_ack_one_cycle: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge held longer than one cycle");

  a_ack_needs_strobe: assert property (
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("Acknowledge without a request");

endmodule : pfcbl_top

// ==== dv/pfcbl_gate_model.sv ====
`timescale 1ns/1ns
// Gate driver model: counts commanded on-cycles while the window is open
module pfcbl_gate_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic gate_i,
  input wire logic win_i,
  output logic [15:0] on_cnt_o
);
  // On-time counter
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) on_cnt_o <= 16'h0000;
    else if (win_i && gate_i) on_cnt_o <= on_cnt_o + 16'h0001;
  end
endmodule : pfcbl_gate_model

// ==== dv/tb_top.sv ====
`timescale 1ns/1ns
`include "pfcbl_defs.svh"
module tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [17:0] adr = 18'h00000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic ack, pwm, irq;
  logic lvv = 1'b0;
  logic busv = 1'b0;
  logic win = 1'b0;
  logic [15:0] lv = 16'h0000;
  logic [15:0] bus = 16'h0000;
  logic [15:0] q, on_cnt;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;

  pfcbl_top i_dut (.clk_i(clk), .resetn_i(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .line_voltage_sample_i(lv), .line_sample_valid_i(lvv),
    .dc_bus_voltage_i(bus), .dc_bus_valid_i(busv), .pwm_o(pwm), .irq_o(irq));
  pfcbl_gate_model i_gate (.clk_i(clk), .resetn_i(resetn), .gate_i(pwm), .win_i(win),
    .on_cnt_o(on_cnt));

  // Clock and run limit
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [15:0] idx, input logic [15:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'h3;
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    // Acknowledge stands for one cycle only
    chk("ack drop", 16'h0000, {15'h0000, ack});
  endtask : wb

  task automatic rd(input string name, input logic [15:0] idx, input logic [15:0] exp);
    wb(1'b0, idx, 16'h0000);
    chk(name, exp, q);
  endtask : rd

  // One sample pulse on the line or the bus input
  task automatic pulse(input logic on_bus, input logic [15:0] v);
    if (on_bus) begin
      bus <= v;
      busv <= 1'b1;
    end else begin
      lv <= v;
      lvv <= 1'b1;
    end
    @(posedge clk);
    busv <= 1'b0;
    lvv <= 1'b0;
    @(posedge clk);
  endtask : pulse

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd("avg reset", `PFCBL_IDX_RELOAD, 16'h0000);
    rd("duty reset", `PFCBL_IDX_DUTY, 16'h0000);
    rd("out reset", `PFCBL_IDX_OUTPUT, 16'h0000);
    wb(1'b1, `PFCBL_IDX_KP, 16'hffff);
    rd("kp", `PFCBL_IDX_KP, 16'h7fff);
    wb(1'b1, `PFCBL_IDX_KI, 16'hffff);
    rd("ki", `PFCBL_IDX_KI, 16'h7fff);
    wb(1'b1, `PFCBL_IDX_DUTY, 16'hffff);
    rd("duty", `PFCBL_IDX_DUTY, 16'h0fff);
    rd("unmapped", 16'h4200, 16'h0000);
    wb(1'b1, `PFCBL_IDX_RELOAD, 16'h0005);
    rd("reload read", `PFCBL_IDX_RELOAD, 16'h0000);
    wb(1'b1, `PFCBL_IDX_DUTY, 16'h0003);
    // Period of 10 cycles, 6 of them on with the crossing held
    repeat (20) @(posedge clk);
    win <= 1'b1;
    repeat (100) @(posedge clk);
    win <= 1'b0;
    @(posedge clk);
    chk("pwm on time", 16'h003c, on_cnt);
    rd("status", `PFCBL_IDX_STATUS, 16'h0001);
    wb(1'b1, `PFCBL_IDX_MASK, 16'h0001);
    repeat (2) @(posedge clk);
    chk("irq on", 16'h0001, {15'h0000, irq});
    wb(1'b1, `PFCBL_IDX_MASK, 16'h0000);
    repeat (2) @(posedge clk);
    chk("irq off", 16'h0000, {15'h0000, irq});
    for (int i = 0; i < 256; i++) pulse(1'b0, 16'hfffd);
    rd("average", `PFCBL_IDX_RELOAD, 16'hfffd);
    wb(1'b0, `PFCBL_IDX_STATUS, 16'h0000);
    chk("avg event", 16'h0004, q & 16'h0004);
    wb(1'b1, `PFCBL_IDX_STATUS, 16'h0004);
    wb(1'b0, `PFCBL_IDX_STATUS, 16'h0000);
    chk("avg clear", 16'h0000, q & 16'h0004);
    // Loop with correction off: setpoint is the error, bus ignored
    wb(1'b1, `PFCBL_IDX_KP, 16'h0400);
    wb(1'b1, `PFCBL_IDX_KI, 16'h4000);
    wb(1'b1, `PFCBL_IDX_CEILING, 16'h7fff);
    wb(1'b1, `PFCBL_IDX_FLOOR, 16'h8000);
    wb(1'b1, `PFCBL_IDX_SETPOINT, 16'h0064);
    pulse(1'b1, 16'h0010);
    rd("loop out 1", `PFCBL_IDX_OUTPUT, 16'h0096);
    pulse(1'b1, 16'h0010);
    rd("loop out 2", `PFCBL_IDX_OUTPUT, 16'h00c8);
    wb(1'b1, `PFCBL_IDX_CEILING, 16'h00b4);
    pulse(1'b1, 16'h0010);
    rd("ceiling", `PFCBL_IDX_OUTPUT, 16'h00b4);
    wb(1'b1, `PFCBL_IDX_FLOOR, 16'h0064);
    wb(1'b1, `PFCBL_IDX_SETPOINT, 16'hff9c);
    pulse(1'b1, 16'h0010);
    rd("floor", `PFCBL_IDX_OUTPUT, 16'h0064);
    wb(1'b1, `PFCBL_IDX_OUTPUT, 16'h8001);
    rd("out write", `PFCBL_IDX_OUTPUT, 16'h8001);
    // Correction on: error is setpoint minus bus, duty follows the output
    wb(1'b1, `PFCBL_IDX_OUTPUT, 16'h0064);
    wb(1'b1, `PFCBL_IDX_CEILING, 16'h7fff);
    wb(1'b1, `PFCBL_IDX_CONTROL, 16'h0001);
    wb(1'b1, `PFCBL_IDX_SETPOINT, 16'h012c);
    pulse(1'b1, 16'h0064);
    rd("loop out en", `PFCBL_IDX_OUTPUT, 16'h01f4);
    rd("duty auto", `PFCBL_IDX_DUTY, 16'h003e);
    wb(1'b1, `PFCBL_IDX_DUTY, 16'h0123);
    rd("duty locked", `PFCBL_IDX_DUTY, 16'h003e);
    finish_test();
  end
endmodule : tb_top
